/* File: pdmac_channel.sv */
/*
 Peripheral DMA channel: AHB-Lite registers, receive and transmit engines.
 Assumes a memory port answering with mem_done, and ready strobes.
*/
// Decided for this implementation: the AHB-Lite register port and the register offsets.
// Summary of operation
// - Half duplex shares one current pointer
// - Zero count stops transfer; nonzero starts
// - Half duplex shares one current counter
// - Receive next pointer holds following address
// - Receive next count is sixteen bits
// - Transmit next pointer holds following address
// - Transmit next count is sixteen bits
// - Half duplex shares one next counter
// - Receive enable bit sets unless disable
// - Receive disable bit clears receive enable
// - Transmit enable bit sets transmit enable unless disable
// - Transmit disable bit clears transmit enable
// - Half duplex receive enable drops transmit
// - Half duplex receive disable drops transmit
// - Half duplex transmit enable yields to receive
// - Half duplex transmit disable drops receive
// - Status bit zero shows receive enable
// - Status bit eight shows transmit enable
// - Current reloads from nonzero next when its count steps to zero
// - Pointer advances by unit size
// - Transmit end and empty flags
// - Receive end and full flags
`timescale 1ns/1ns
`include "pdmac_defines.svh"
module pdmac_channel #(
    parameter int HALF_DUPLEX = 0
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic                 rx_ready,
    input  wire logic                 tx_ready,
    input  wire logic [31:0]          rx_holding,
    output logic [31:0]               tx_holding,
    output logic                      tx_holding_load,
    output logic                      mem_req,
    output pdmac_pkg::pdmac_mreq_t    mem_cmd,
    input  wire logic                 mem_done,
    input  wire logic [31:0]          mem_rdata,
    output pdmac_pkg::pdmac_flags_t   flags
);

    if (HALF_DUPLEX != 0 && HALF_DUPLEX != 1) begin : g_bad_mode
        $error("HALF_DUPLEX must be 0 or 1");
    end

    localparam logic HD = (HALF_DUPLEX == 1);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [31:0] rx_buffer_address;
    logic [31:0] tx_buffer_address_r;
    logic [15:0] rx_buffer_size;
    logic [15:0] tx_buffer_size_r;
    logic [31:0] rx_following_address;
    logic [31:0] tx_following_address_r;
    logic [15:0] rx_following_size;
    logic [15:0] tx_following_size_r;
    logic        rx_on;
    logic        tx_on;
    logic [1:0]  unit_size;
    logic        rx_pend;
    logic        tx_pend;
    logic [31:0] rx_held;
    pdmac_pkg::pdmac_state_t state;

    // Half duplex: tx names alias the rx registers
    wire [31:0] tx_buffer_address = HD ? rx_buffer_address
                                       : tx_buffer_address_r;
    wire [15:0] tx_buffer_size = HD ? rx_buffer_size
                                    : tx_buffer_size_r;
    wire [31:0] tx_following_address = HD ? rx_following_address
                                          : tx_following_address_r;
    wire [15:0] tx_following_size = HD ? rx_following_size
                                       : tx_following_size_r;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase capture; zero wait states

    logic        ph_wr;
    logic        ph_rd;
    logic [11:0] ph_ofs;

    wire addr_taken = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr  <= 1'b0;
            ph_rd  <= 1'b0;
            ph_ofs <= 12'h000;
        end else begin
            ph_wr  <= addr_taken && hwrite;
            ph_rd  <= addr_taken && !hwrite;
            ph_ofs <= haddr[11:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    function automatic logic wr_hit(input logic [11:0] ofs);
        wr_hit = ph_wr && (ph_ofs == ofs);
    endfunction

    wire w_rp   = wr_hit(`PDMAC_OFS_RX_POINTER);
    wire w_rc   = wr_hit(`PDMAC_OFS_RX_COUNT);
    wire w_tp   = wr_hit(`PDMAC_OFS_TX_POINTER);
    wire w_tc   = wr_hit(`PDMAC_OFS_TX_COUNT);
    wire w_rnp  = wr_hit(`PDMAC_OFS_RX_NEXT_POINTER);
    wire w_rnc  = wr_hit(`PDMAC_OFS_RX_NEXT_COUNT);
    wire w_tnp  = wr_hit(`PDMAC_OFS_TX_NEXT_POINTER);
    wire w_tnc  = wr_hit(`PDMAC_OFS_TX_NEXT_COUNT);
    wire w_ctl  = wr_hit(`PDMAC_OFS_CONTROL);
    wire w_mode = wr_hit(`PDMAC_OFS_MODE);

    // Half duplex: either name writes the one register
    wire wr_cur_ptr_rx = w_rp || (HD && w_tp);
    wire wr_cur_cnt_rx = w_rc || (HD && w_tc);
    wire wr_nxt_ptr_rx = w_rnp || (HD && w_tnp);
    wire wr_nxt_cnt_rx = w_rnc || (HD && w_tnc);

    ////////////////////////////////////////////////////////////////////////
    // Control decode

    wire c_rx_en  = w_ctl && hwdata[`PDMAC_BIT_RX_EN];
    wire c_rx_dis = w_ctl && hwdata[`PDMAC_BIT_RX_DIS];
    wire c_tx_en  = w_ctl && hwdata[`PDMAC_BIT_TX_EN];
    wire c_tx_dis = w_ctl && hwdata[`PDMAC_BIT_TX_DIS];

    // Disable wins over enable in the same write
    wire rx_set = c_rx_en && !c_rx_dis && !(HD && c_tx_dis);
    wire rx_clr = c_rx_dis || (HD && c_tx_dis);
    wire tx_set = c_tx_en && !c_tx_dis && !(HD && (c_rx_en || c_rx_dis));
    wire tx_clr = c_tx_dis || (HD && (rx_set || c_rx_dis));

    wire next_rx_on = rx_set ? 1'b1 : (rx_clr ? 1'b0 : rx_on);
    wire next_tx_on = tx_set ? 1'b1 : (tx_clr ? 1'b0 : tx_on);

    ////////////////////////////////////////////////////////////////////////
    // Transfer engine

    wire [31:0] step = (unit_size == 2'd2) ? 32'h0000_0004 :
                       (unit_size == 2'd1) ? 32'h0000_0002 :
                                             32'h0000_0001;

    // Nonzero count and an enabled channel allow requests
    wire rx_go = rx_on && (rx_buffer_size != 16'h0000);
    wire tx_go = tx_on && (tx_buffer_size != 16'h0000);

    wire rx_unit_done = (state == pdmac_pkg::PDMAC_RX_BUS) && mem_done;
    wire tx_unit_done = (state == pdmac_pkg::PDMAC_TX_BUS) && mem_done;
    // Half duplex: one counter, whichever direction moved it
    wire rx_cnt_step = rx_unit_done || (HD && tx_unit_done);

    wire [15:0] rx_cnt_dec = rx_buffer_size - 16'h0001;
    wire [15:0] tx_cnt_dec = tx_buffer_size_r - 16'h0001;
    wire rx_last = rx_cnt_step && (rx_cnt_dec == 16'h0000);
    wire tx_last = (HD ? rx_cnt_step : tx_unit_done)
                   && (tx_buffer_size == 16'h0001);
    wire rx_reload = rx_last && (rx_following_size != 16'h0000);
    wire tx_reload = !HD && tx_last
                     && (tx_following_size_r != 16'h0000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_buffer_address <= `PDMAC_RST_WORD;
            rx_buffer_size    <= `PDMAC_RST_COUNT;
            rx_following_address <= `PDMAC_RST_WORD;
            rx_following_size <= `PDMAC_RST_COUNT;
        end else begin
            if (rx_reload) begin
                rx_buffer_address <= rx_following_address;
                rx_buffer_size    <= rx_following_size;
                rx_following_size <= `PDMAC_RST_COUNT;
                rx_following_address <= `PDMAC_RST_WORD;
            end else if (rx_cnt_step) begin
                rx_buffer_address <= rx_buffer_address + step;
                rx_buffer_size    <= rx_cnt_dec;
            end
            if (wr_cur_ptr_rx) begin
                rx_buffer_address <= hwdata;
            end
            if (wr_cur_cnt_rx) begin
                rx_buffer_size <= hwdata[15:0];
            end
            if (wr_nxt_ptr_rx) begin
                rx_following_address <= hwdata;
            end
            if (wr_nxt_cnt_rx) begin
                rx_following_size <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_buffer_address_r    <= `PDMAC_RST_WORD;
            tx_buffer_size_r       <= `PDMAC_RST_COUNT;
            tx_following_address_r <= `PDMAC_RST_WORD;
            tx_following_size_r    <= `PDMAC_RST_COUNT;
        end else if (!HD) begin
            if (tx_reload) begin
                tx_buffer_address_r    <= tx_following_address_r;
                tx_buffer_size_r       <= tx_following_size_r;
                tx_following_address_r <= `PDMAC_RST_WORD;
                tx_following_size_r    <= `PDMAC_RST_COUNT;
            end else if (tx_unit_done) begin
                tx_buffer_address_r <= tx_buffer_address_r + step;
                tx_buffer_size_r    <= tx_cnt_dec;
            end
            if (w_tp) begin
                tx_buffer_address_r <= hwdata;
            end
            if (w_tc) begin
                tx_buffer_size_r <= hwdata[15:0];
            end
            if (w_tnp) begin
                tx_following_address_r <= hwdata;
            end
            if (w_tnc) begin
                tx_following_size_r <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_on     <= 1'b0;
            tx_on     <= 1'b0;
            unit_size <= 2'd0;
        end else begin
            rx_on <= next_rx_on;
            tx_on <= next_tx_on;
            if (w_mode) begin
                unit_size <= (hwdata[1:0] == 2'd3) ? 2'd2 : hwdata[1:0];
            end
        end
    end

    // Strobes wait until served; set beats clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_pend       <= 1'b0;
            tx_pend       <= 1'b0;
            rx_held       <= `PDMAC_RST_WORD;
        end else begin
            if (rx_ready && rx_go) begin
                rx_pend <= 1'b1;
                rx_held <= rx_holding;
            end else if (rx_unit_done || !rx_go) begin
                rx_pend <= 1'b0;
            end
            if (tx_ready && tx_go) begin
                tx_pend <= 1'b1;
            end else if (tx_unit_done || !tx_go) begin
                tx_pend <= 1'b0;
            end
        end
    end

    wire start_rx = (state == pdmac_pkg::PDMAC_IDLE) && rx_pend && rx_go;
    wire start_tx = (state == pdmac_pkg::PDMAC_IDLE) && !start_rx
                    && tx_pend && tx_go;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= pdmac_pkg::PDMAC_IDLE;
        end else begin
            unique case (state)
                pdmac_pkg::PDMAC_IDLE: begin
                    if (start_rx) begin
                        state <= pdmac_pkg::PDMAC_RX_BUS;
                    end else if (start_tx) begin
                        state <= pdmac_pkg::PDMAC_TX_BUS;
                    end
                end
                pdmac_pkg::PDMAC_RX_BUS,
                pdmac_pkg::PDMAC_TX_BUS: begin
                    if (mem_done) begin
                        state <= pdmac_pkg::PDMAC_IDLE;
                    end
                end
            endcase
        end
    end

    assign mem_req = (state != pdmac_pkg::PDMAC_IDLE);
    always_comb begin
        mem_cmd.size  = unit_size;
        mem_cmd.write = (state == pdmac_pkg::PDMAC_RX_BUS);
        mem_cmd.addr  = mem_cmd.write ? rx_buffer_address
                                      : tx_buffer_address;
        mem_cmd.wdata = rx_held;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_holding      <= `PDMAC_RST_WORD;
            tx_holding_load <= 1'b0;
        end else begin
            tx_holding_load <= tx_unit_done;
            if (tx_unit_done) begin
                tx_holding <= mem_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: set on the final unit, cleared by a nonzero count write

    wire rx_nz_wr = (wr_cur_cnt_rx || wr_nxt_cnt_rx) && (hwdata[15:0] != 16'h0000);
    wire tx_nz_wr = (w_tc || w_tnc) && (hwdata[15:0] != 16'h0000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= '0;
        end else begin
            if (rx_last) begin
                flags.end_of_receive <= 1'b1;
            end else if (rx_nz_wr) begin
                flags.end_of_receive <= 1'b0;
            end
            if (rx_last && rx_following_size == 16'h0000) begin
                flags.receive_buffer_full <= 1'b1;
            end else if (tx_nz_wr || (HD && rx_nz_wr)) begin
                flags.receive_buffer_full <= 1'b0;
            end
            if (tx_last) begin
                flags.end_of_transmit <= 1'b1;
            end else if (tx_nz_wr || (HD && rx_nz_wr)) begin
                flags.end_of_transmit <= 1'b0;
            end
            if (tx_last && tx_following_size == 16'h0000) begin
                flags.transmit_buffer_empty <= 1'b1;
            end else if (tx_nz_wr || (HD && rx_nz_wr)) begin
                flags.transmit_buffer_empty <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; control and unmapped offsets read zero

    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (ph_ofs)
            `PDMAC_OFS_RX_POINTER:      rd_word = rx_buffer_address;
            `PDMAC_OFS_RX_COUNT:        rd_word = {16'h0000, rx_buffer_size};
            `PDMAC_OFS_TX_POINTER:      rd_word = tx_buffer_address;
            `PDMAC_OFS_TX_COUNT:        rd_word = {16'h0000, tx_buffer_size};
            `PDMAC_OFS_RX_NEXT_POINTER: rd_word = rx_following_address;
            `PDMAC_OFS_RX_NEXT_COUNT:   rd_word = {16'h0000, rx_following_size};
            `PDMAC_OFS_TX_NEXT_POINTER: rd_word = tx_following_address;
            `PDMAC_OFS_TX_NEXT_COUNT:   rd_word = {16'h0000, tx_following_size};
            `PDMAC_OFS_STATUS: begin
                rd_word[`PDMAC_BIT_RX_EN] = rx_on;
                rd_word[`PDMAC_BIT_TX_EN] = tx_on;
            end
            `PDMAC_OFS_FLAGS: begin
                rd_word[`PDMAC_BIT_END_RX]   = flags.end_of_receive;
                rd_word[`PDMAC_BIT_END_TX]   = flags.end_of_transmit;
                rd_word[`PDMAC_BIT_RX_FULL]  = flags.receive_buffer_full;
                rd_word[`PDMAC_BIT_TX_EMPTY] = flags.transmit_buffer_empty;
            end
            `PDMAC_OFS_MODE:            rd_word = {30'h0, unit_size};
            default:                    rd_word = 32'h0000_0000;
        endcase
    end

    assign hrdata = ph_rd ? rd_word : 32'h0000_0000;

endmodule // pdmac_channel

/* File: pdmac_channel_assertions.sv */
/*
 Checker of memory handshake, holding load and flags.
 Assumes binding onto every pdmac_channel.
*/
`timescale 1ns/1ns
module pdmac_channel_checker (
    input wire logic                    hclk,
    input wire logic                    hresetn,
    input wire logic                    mem_req,
    input wire logic                    mem_done,
    input wire logic [31:0]             mem_rdata,
    input wire pdmac_pkg::pdmac_mreq_t  mem_cmd,
    input wire logic [31:0]             tx_holding,
    input wire logic                    tx_holding_load,
    input wire pdmac_pkg::pdmac_flags_t flags
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic tx_done = mem_req && mem_done && !mem_cmd.write;
    wire logic rx_done = mem_req && mem_done && mem_cmd.write;
    ////////////////////////////////////////////////////////////////////////
    property p_req_holds; mem_req && !mem_done |=> mem_req; endproperty
    a_req_holds: assert property (p_req_holds)
        else $error("request dropped early");
    property p_cmd_stable; mem_req && !mem_done |=> $stable(mem_cmd);
    endproperty
    a_cmd_stable: assert property (p_cmd_stable)
        else $error("command moved");
    property p_req_ends; mem_req && mem_done |=> !mem_req; endproperty
    a_req_ends: assert property (p_req_ends)
        else $error("request held after done");
    property p_load; tx_done |=> tx_holding_load
        && tx_holding == $past(mem_rdata); endproperty
    a_load: assert property (p_load)
        else $error("holding not loaded");
    property p_eot; $rose(flags.end_of_transmit) |-> $past(tx_done);
    endproperty
    a_eot: assert property (p_eot)
        else $error("stray end of transmit");
    property p_eor; $rose(flags.end_of_receive) |-> $past(rx_done);
    endproperty
    a_eor: assert property (p_eor)
        else $error("stray end of receive");
    property p_empty;
        $rose(flags.transmit_buffer_empty) |-> flags.end_of_transmit;
    endproperty
    a_empty: assert property (p_empty)
        else $error("empty without end");
    property p_full;
        $rose(flags.receive_buffer_full) |-> flags.end_of_receive;
    endproperty
    a_full: assert property (p_full)
        else $error("full without end");
endmodule // pdmac_channel_checker

bind pdmac_channel pdmac_channel_checker i_pdmac_channel_checker (
    .hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_done(mem_done), .mem_rdata(mem_rdata), .mem_cmd(mem_cmd),
    .tx_holding(tx_holding), .tx_holding_load(tx_holding_load),
    .flags(flags));

/* File: pdmac_defines.svh */
/*
 DMA channel offsets, bit positions and reset values.
 Assumes inclusion by bare name.
*/
`ifndef PDMAC_DEFINES_SVH
`define PDMAC_DEFINES_SVH
`define PDMAC_OFS_RX_POINTER       12'h0100
`define PDMAC_OFS_RX_COUNT         12'h0104
`define PDMAC_OFS_TX_POINTER       12'h0108
`define PDMAC_OFS_TX_COUNT         12'h010C
`define PDMAC_OFS_RX_NEXT_POINTER  12'h0110
`define PDMAC_OFS_RX_NEXT_COUNT    12'h0114
`define PDMAC_OFS_TX_NEXT_POINTER  12'h0118
`define PDMAC_OFS_TX_NEXT_COUNT    12'h011C
`define PDMAC_OFS_CONTROL          12'h0120
`define PDMAC_OFS_STATUS           12'h0124
`define PDMAC_OFS_FLAGS            12'h0128
`define PDMAC_OFS_MODE             12'h012C
`define PDMAC_BIT_RX_EN            0
`define PDMAC_BIT_RX_DIS           1
`define PDMAC_BIT_TX_EN            8
`define PDMAC_BIT_TX_DIS           9
`define PDMAC_BIT_END_RX           0
`define PDMAC_BIT_END_TX           1
`define PDMAC_BIT_RX_FULL          2
`define PDMAC_BIT_TX_EMPTY         3
`define PDMAC_RST_WORD             32'h0000_0000
`define PDMAC_RST_COUNT            16'h0000
`endif

/* File: pdmac_mem_model.sv */
/*
 Bus matrix model: answers at once or after three waits.
 Assumes mem_req holds until mem_done.
*/
`timescale 1ns/1ns
module pdmac_mem_model (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   slow,
    input  wire logic                   mem_req,
    input  wire pdmac_pkg::pdmac_mreq_t mem_cmd,
    output logic                        mem_done,
    output logic [31:0]                 mem_rdata
);
    logic [2:0]  wait_cnt;
    logic [31:0] noise;
    wire logic   grant = mem_req && !mem_done
                         && (!slow || wait_cnt == 3'h3);
    // Churn outside answers so stale read data can never match
    assign mem_rdata = mem_done ? ~mem_cmd.addr : noise;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_done <= 1'b0;
            wait_cnt <= 3'h0;
            noise    <= 32'h0000_0000;
        end else begin
            mem_done <= grant;
            wait_cnt <= (mem_req && !mem_done) ? wait_cnt + 3'h1 : 3'h0;
            noise    <= noise + 32'h9E37_79B9;
        end
    end
endmodule // pdmac_mem_model

/* File: pdmac_pkg.sv */
/*
 Types of the peripheral DMA channel. Assumes nothing else.
*/
package pdmac_pkg;
    typedef enum logic [1:0] {
        PDMAC_SZ_BYTE,
        PDMAC_SZ_HALF,
        PDMAC_SZ_WORD
    } pdmac_size_t;
    typedef enum logic [1:0] {
        PDMAC_IDLE,
        PDMAC_RX_BUS,
        PDMAC_TX_BUS
    } pdmac_state_t;
    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic [31:0] wdata;
        logic [1:0]  size;
    } pdmac_mreq_t;
    typedef struct packed {
        logic end_of_receive;
        logic end_of_transmit;
        logic receive_buffer_full;
        logic transmit_buffer_empty;
    } pdmac_flags_t;
endpackage

/* File: tb.sv */
/*
 Testbench: register rows for both duplex variants, then transfers.
 Assumes the channel, its checker and the memory model.
*/
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic hd; logic [11:0] wofs; logic [31:0] wd;
        logic [11:0] rofs; logic [31:0] exp;
    } pdmac_row_t;
    logic        hclk, hresetn, hsel, hsel_hd, hwrite, hreadyout, slow, hresp;
    logic        rx_ready, tx_ready, tx_holding_load, mem_req, mem_done;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, hrdata_hd, rx_holding;
    logic [31:0] tx_holding, mem_rdata, rd;
    pdmac_pkg::pdmac_mreq_t  mem_cmd;
    pdmac_pkg::pdmac_flags_t flags;
    int          errors = 0, comparisons = 0, cycles = 0;
    pdmac_row_t  rows [23] = '{
        '{1'b0, 12'h108, 32'hDEAD_BEEF, 12'h108, 32'hDEAD_BEEF},
        '{1'b0, 12'h10C, 32'hABCD_1234, 12'h10C, 32'h0000_1234},
        '{1'b0, 12'h110, 32'h1234_5678, 12'h110, 32'h1234_5678},
        '{1'b0, 12'h114, 32'hFFFF_FFFF, 12'h114, 32'h0000_FFFF},
        '{1'b0, 12'h118, 32'h8765_4321, 12'h118, 32'h8765_4321},
        '{1'b0, 12'h11C, 32'h0001_8000, 12'h11C, 32'h0000_8000},
        '{1'b0, 12'h124, 32'hFFFF_FFFF, 12'h124, 32'h0000_0000},
        '{1'b0, 12'h0FC, 32'hFFFF_FFFF, 12'h0FC, 32'h0000_0000},
        '{1'b0, 12'h120, 32'h0000_0001, 12'h124, 32'h0000_0001},
        '{1'b0, 12'h120, 32'h0000_0100, 12'h124, 32'h0000_0101},
        '{1'b0, 12'h120, 32'h0000_0000, 12'h120, 32'h0000_0000},
        '{1'b0, 12'h120, 32'h0000_0003, 12'h124, 32'h0000_0100},
        '{1'b0, 12'h120, 32'h0000_0301, 12'h124, 32'h0000_0001},
        '{1'b0, 12'h120, 32'h0000_0002, 12'h124, 32'h0000_0000},
        '{1'b1, 12'h100, 32'h1111_0000, 12'h108, 32'h1111_0000},
        '{1'b1, 12'h10C, 32'h0000_0007, 12'h104, 32'h0000_0007},
        '{1'b1, 12'h118, 32'h2222_0000, 12'h110, 32'h2222_0000},
        '{1'b1, 12'h114, 32'h0000_0009, 12'h11C, 32'h0000_0009},
        '{1'b1, 12'h120, 32'h0000_0100, 12'h124, 32'h0000_0100},
        '{1'b1, 12'h120, 32'h0000_0001, 12'h124, 32'h0000_0001},
        '{1'b1, 12'h120, 32'h0000_0200, 12'h124, 32'h0000_0000},
        '{1'b1, 12'h120, 32'h0000_0100, 12'h124, 32'h0000_0100},
        '{1'b1, 12'h120, 32'h0000_0002, 12'h124, 32'h0000_0000}
    };
    pdmac_channel i_pdmac_channel (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rx_ready(rx_ready), .tx_ready(tx_ready),
        .rx_holding(rx_holding), .tx_holding(tx_holding),
        .tx_holding_load(tx_holding_load), .mem_req(mem_req),
        .mem_cmd(mem_cmd), .mem_done(mem_done), .mem_rdata(mem_rdata),
        .flags(flags));
    // Half duplex twin: only its registers are exercised
    pdmac_channel #(.HALF_DUPLEX(1)) i_pdmac_channel_hd (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel_hd), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(hrdata_hd),
        .rx_ready(rx_ready), .tx_ready(tx_ready), .rx_holding(rx_holding),
        .tx_holding(), .tx_holding_load(), .mem_req(), .mem_cmd(),
        .mem_done(1'b0), .mem_rdata(32'h0000_0000), .flags());
    pdmac_mem_model i_pdmac_mem_model (
        .hclk(hclk), .hresetn(hresetn), .slow(slow), .mem_req(mem_req),
        .mem_cmd(mem_cmd), .mem_done(mem_done), .mem_rdata(mem_rdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic phase(input logic hd, output logic [31:0] d);
        do begin
            @(negedge hclk);
            d = hd ? hrdata_hd : hrdata;
        end while (hreadyout !== 1'b1);
        @(posedge hclk);
    endtask
    task automatic ahb(input logic hd, w, input logic [11:0] ofs,
                       input logic [31:0] wd, output logic [31:0] d);
        hsel    <= !hd;
        hsel_hd <= hd;
        haddr   <= {20'h0_0000, ofs};
        hwrite  <= w;
        htrans  <= 2'b10;
        phase(hd, d);
        {hsel, hsel_hd} <= 2'b00;
        htrans  <= 2'b00;
        hwdata  <= wd;
        phase(hd, d);
    endtask
    task automatic wr(input logic [11:0] ofs, input logic [31:0] wd);
        ahb(1'b0, 1'b1, ofs, wd, rd);
    endtask
    task automatic rdx(input logic [11:0] ofs, input logic [31:0] exp);
        ahb(1'b0, 1'b0, ofs, 32'h0000_0000, rd);
        chk("register", rd, exp);
    endtask
    // One strobe and the access it causes
    task automatic unit(input logic tx, input logic [31:0] addr);
        int n = 0;
        if (tx) tx_ready <= 1'b1;
        else rx_ready <= 1'b1;
        @(posedge hclk);
        {tx_ready, rx_ready} <= 2'b00;
        do begin
            @(negedge hclk);
            n++;
        end while (!(mem_req === 1'b1 && mem_done === 1'b1) && n < 50);
        chk("unit done", {29'h0, hresp, mem_req, mem_done}, 32'h3);
        chk("unit address", mem_cmd.addr, addr);
        chk("unit write", {31'h0, mem_cmd.write}, {31'h0, !tx});
        if (!tx) chk("rx byte", {24'h0, mem_cmd.wdata[7:0]},
                     {24'h0, rx_holding[7:0]});
        @(negedge hclk);
        if (tx) chk("tx holding", tx_holding, ~addr);
        @(posedge hclk);
    endtask
    task tally_and_finish;
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish;
        end
    end
    initial begin
        {hresetn, hsel, hsel_hd, hwrite, slow, rx_ready, tx_ready} = '0;
        {htrans, hsize, haddr, hwdata} = {2'b00, 3'b010, 64'h0};
        rx_holding = 32'h5A5A_00C3;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 20; i++) begin
            ahb(i[0], 1'b0, 12'h100 + 12'(i / 2 * 4), 32'h0, rd);
            chk("reset value", rd, 32'h0000_0000);
        end
        for (int i = 0; i < 23; i++) begin
            ahb(rows[i].hd, 1'b1, rows[i].wofs, rows[i].wd, rd);
            ahb(rows[i].hd, 1'b0, rows[i].rofs, 32'h0, rd);
            chk($sformatf("row %0d", i), rd, rows[i].exp);
        end
        wr(12'h12C, 32'h0000_0002);
        wr(12'h108, 32'h0000_1000);
        wr(12'h10C, 32'h0000_0002);
        wr(12'h118, 32'h0000_2000);
        wr(12'h11C, 32'h0000_0001);
        wr(12'h120, 32'h0000_0100);
        unit(1'b1, 32'h0000_1000);
        unit(1'b1, 32'h0000_1004);
        chk("flags", {28'h0, flags}, 32'h0000_0004);
        rdx(12'h11C, 32'h0000_0000);
        unit(1'b1, 32'h0000_2000);
        chk("flags", {28'h0, flags}, 32'h0000_0005);
        rdx(12'h108, 32'h0000_2004);
        tx_ready <= 1'b1;
        @(posedge hclk);
        tx_ready <= 1'b0;
        repeat (3) @(negedge hclk);
        chk("idle request", {31'h0, mem_req}, 32'h0000_0000);
        @(posedge hclk);
        slow <= 1'b1;
        wr(12'h114, 32'h0000_0000);
        wr(12'h12C, 32'h0000_0000);
        wr(12'h100, 32'h0000_3000);
        wr(12'h104, 32'h0000_0002);
        wr(12'h120, 32'h0000_0001);
        unit(1'b0, 32'h0000_3000);
        unit(1'b0, 32'h0000_3001);
        rdx(12'h128, 32'h0000_000F);
        rdx(12'h100, 32'h0000_3002);
        wr(12'h11C, 32'h0000_0005);
        rdx(12'h128, 32'h0000_0001);
        tally_and_finish;
    end
endmodule // tb
